/* src/mie_exec.sv */
// Instruction execute core with a Wishbone register slave
// Function
// - Each instruction is one 14-bit word split into an opcode and operand fields.
// - Byte-oriented results go to the accumulator when the destination bit is 0, else to the file register.
// - Bit-oriented instructions pick one of eight bits of the register named by the file address field.
// - Literal and control instructions carry an 8-bit or 11-bit constant operand.
// - The file address field is seven bits wide, covering 0x00 to 0x7f.
// - One instruction cycle is four oscillator periods and all timing counts in such cycles.
// - Instructions take one cycle, or two with a no-operation second cycle when a skip is taken or the PC changes.
// - Any instruction naming a file register reads it first, modifies, then stores, even if it only writes.
// - Rotate left moves the register left through carry, old carry into bit 0, old bit 7 into carry.
// - Rotate right moves the register right through carry, old carry into bit 7, old bit 0 into carry.
// - Literal minus accumulator goes to the accumulator, carry clears when the accumulator is larger, nibble carry when its low nibble is larger.
// - Sleep clears the watchdog and its prescaler, sets the expiry flag, clears powerdown and stops the oscillator.
// - The powerdown flag is set at power-up and cleared only by sleep.
`timescale 1ns/1ps
module mie_exec
	import mie_pkg::*;
#(
	parameter int unsigned AW = 8
)(
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [AW-1:0] wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	output logic               file_rd_o,
	output logic               file_wr_o,
	output logic      [6:0]    file_addr_o,
	output logic      [7:0]    file_wdata_o,
	input  wire logic [7:0]    file_rdata_i,
	input  wire logic          wdt_expired_i,
	output logic               watchdog_clear_o,
	output logic               prescaler_clear_o,
	output logic               osc_stop_o
);

	if (AW < 5)
		$error("mie_exec: AW must be at least 5");

	logic [1:0]  rst_sync_q;
	logic        rst_n_s;
	mie_state_e  state_q;
	logic [1:0]  qph_q;
	logic [13:0] ir_q;
	mie_dec_s    dec;
	logic [7:0]  acc_q;
	logic [7:0]  fdat_q;
	logic [10:0] pc_q;
	logic        c_q;
	logic        dc_q;
	logic        z_q;
	logic        powerdown_flag_q;
	logic        watchdog_expiry_flag_q;
	logic        ill_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic        wb_hit;
	logic        wb_wr;
	logic        commit;
	logic        issue;
	logic        wake;
	logic        two_cyc;
	logic [7:0]  res;
	logic        wr_acc;
	logic        wr_file;
	logic        c_n;
	logic        dc_n;
	logic        z_n;
	logic        take_skip;
	logic [7:0]  bitmask;
	logic [8:0]  diff;
	logic [4:0]  ndiff;

	// Reset release
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n_s = rst_sync_q[1];

	// Bus decode
	assign wb_hit = wb_cyc_i && wb_stb_i && !ack_q;
	assign wb_wr  = wb_hit && wb_we_i && wb_sel_i[0];
	assign issue  = wb_wr && wb_sel_i[1] && wb_adr_i == AW'(OFS_INSTR) && state_q == ST_IDLE;
	assign wake   = wdt_expired_i || (wb_wr && wb_adr_i == AW'(OFS_CTRL) && wb_dat_i[CT_WAKE]);
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			ack_q <= 1'b0;
		else
			ack_q <= wb_hit;
	end

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			rdat_q <= 32'h0000_0000;
		else if (wb_hit)
		begin
			case (wb_adr_i)
				AW'(OFS_INSTR): rdat_q <= {18'h00000, ir_q};
				AW'(OFS_ACC):   rdat_q <= {24'h000000, acc_q};
				AW'(OFS_STAT):  rdat_q <= {27'h0000000, watchdog_expiry_flag_q,
					powerdown_flag_q, z_q, dc_q, c_q};
				AW'(OFS_PC):    rdat_q <= {21'h000000, pc_q};
				AW'(OFS_CTRL):  rdat_q <= {29'h00000000, ill_q, state_q == ST_SLEEP,
					state_q != ST_IDLE};
				default:        rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	// Instruction word and field split
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			ir_q <= IR_RST;
		else if (issue)
			ir_q <= wb_dat_i[IW-1:0];
	end
	assign dec = mie_decode(ir_q);

	// Sequencer: four phases per instruction cycle
	assign commit = state_q == ST_EXEC && qph_q == Q_COMMIT;
	assign two_cyc = dec.op == OP_JUMP || take_skip;

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			qph_q <= Q_DECODE;
		else if (state_q == ST_EXEC || state_q == ST_FLUSH)
			qph_q <= qph_q + 2'h1;
		else
			qph_q <= Q_DECODE;
	end

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:
					if (issue)
						state_q <= ST_EXEC;
				ST_EXEC:
					if (commit)
					begin
						if (dec.op == OP_SLEEP)
							state_q <= ST_SLEEP;
						else if (two_cyc)
							state_q <= ST_FLUSH;
						else
							state_q <= ST_IDLE;
					end
				ST_FLUSH:
					if (qph_q == Q_COMMIT)
						state_q <= ST_IDLE;
				ST_SLEEP:
					if (wake)
						state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign osc_stop_o = state_q == ST_SLEEP;

	// File register read before modify
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			file_rd_o   <= 1'b0;
			file_addr_o <= 7'h00;
		end
		else
		begin
			file_rd_o <= state_q == ST_EXEC && qph_q == Q_DECODE && mie_needs_file(dec.op);
			if (state_q == ST_EXEC && qph_q == Q_DECODE)
				file_addr_o <= dec.faddr;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			fdat_q <= 8'h00;
		else if (state_q == ST_EXEC && qph_q == Q_LATCH)
			fdat_q <= file_rdata_i;
	end

	// Operation
	always_comb
	begin
		res       = fdat_q;
		wr_acc    = 1'b0;
		wr_file   = 1'b0;
		c_n       = c_q;
		dc_n      = dc_q;
		z_n       = z_q;
		take_skip = 1'b0;
		bitmask   = 8'h01 << dec.bsel;
		diff      = {1'b0, dec.lit8} - {1'b0, acc_q};
		ndiff     = {1'b0, dec.lit8[3:0]} - {1'b0, acc_q[3:0]};
		case (dec.op)
			OP_ROT_L:
			begin
				res     = {fdat_q[6:0], c_q};
				c_n     = fdat_q[7];
				wr_acc  = !dec.dest;
				wr_file = dec.dest;
			end
			OP_ROT_R:
			begin
				res     = {c_q, fdat_q[7:1]};
				c_n     = fdat_q[0];
				wr_acc  = !dec.dest;
				wr_file = dec.dest;
			end
			OP_MOVE_F:
			begin
				z_n     = fdat_q == 8'h00;
				wr_acc  = !dec.dest;
				wr_file = dec.dest;
			end
			OP_CLR_F:
			begin
				res     = 8'h00;
				z_n     = 1'b1;
				wr_file = 1'b1;
			end
			OP_BIT_CLR:
			begin
				res     = fdat_q & ~bitmask;
				wr_file = 1'b1;
			end
			OP_BIT_SET:
			begin
				res     = fdat_q | bitmask;
				wr_file = 1'b1;
			end
			OP_SKIP_CLR: take_skip = (fdat_q & bitmask) == 8'h00;
			OP_SKIP_SET: take_skip = (fdat_q & bitmask) != 8'h00;
			OP_LOAD_LIT:
			begin
				res    = dec.lit8;
				wr_acc = 1'b1;
			end
			OP_LIT_SUB:
			begin
				res    = diff[7:0];
				c_n    = !diff[8];
				dc_n   = !ndiff[4];
				z_n    = diff[7:0] == 8'h00;
				wr_acc = 1'b1;
			end
			default: res = fdat_q;
		endcase
	end

	// Accumulator
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			acc_q <= ACC_RST;
		else if (commit && wr_acc)
			acc_q <= res;
		else if (wb_wr && state_q == ST_IDLE && wb_adr_i == AW'(OFS_ACC))
			acc_q <= wb_dat_i[DW-1:0];
	end

	// File register store
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			file_wr_o    <= 1'b0;
			file_wdata_o <= 8'h00;
		end
		else
		begin
			file_wr_o <= commit && wr_file;
			if (commit && wr_file)
				file_wdata_o <= res;
		end
	end

	// Arithmetic flags
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			c_q  <= 1'b0;
			dc_q <= 1'b0;
			z_q  <= 1'b0;
		end
		else if (commit)
		begin
			c_q  <= c_n;
			dc_q <= dc_n;
			z_q  <= z_n;
		end
		else if (wb_wr && state_q == ST_IDLE && wb_adr_i == AW'(OFS_STAT))
		begin
			c_q  <= wb_dat_i[ST_C];
			dc_q <= wb_dat_i[ST_DC];
			z_q  <= wb_dat_i[ST_Z];
		end
	end

	// Power and watchdog flags
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			powerdown_flag_q       <= 1'b1;
			watchdog_expiry_flag_q <= 1'b1;
			watchdog_clear_o       <= 1'b0;
			prescaler_clear_o      <= 1'b0;
		end
		else
		begin
			watchdog_clear_o  <= commit && dec.op == OP_SLEEP;
			prescaler_clear_o <= commit && dec.op == OP_SLEEP;
			if (commit && dec.op == OP_SLEEP)
			begin
				powerdown_flag_q       <= 1'b0;
				watchdog_expiry_flag_q <= 1'b1;
			end
			else if (wdt_expired_i)
				watchdog_expiry_flag_q <= 1'b0;
		end
	end

	// Program counter and illegal word flag
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			pc_q <= PC_RST;
		else if (commit)
		begin
			if (dec.op == OP_JUMP)
				pc_q <= dec.lit11;
			else if (take_skip)
				pc_q <= pc_q + 11'h002;
			else
				pc_q <= pc_q + 11'h001;
		end
		else if (wb_wr && wb_sel_i[1] && state_q == ST_IDLE && wb_adr_i == AW'(OFS_PC))
			pc_q <= wb_dat_i[PCW-1:0];
	end

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			ill_q <= 1'b0;
		else if (commit && dec.op == OP_ILLEGAL)
			ill_q <= 1'b1;
		else if (wb_wr && wb_adr_i == AW'(OFS_CTRL) && wb_dat_i[CT_ILL])
			ill_q <= 1'b0;
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_s);

	a_phase_four_cycles: assert property (issue |=> (state_q == ST_EXEC)[*4] ##1 state_q != ST_EXEC)
		else $error("instruction cycle not four clocks");
	a_flush_second_cycle: assert property (commit && two_cyc && dec.op != OP_SLEEP
		|=> (state_q == ST_FLUSH)[*4] ##1 state_q == ST_IDLE)
		else $error("two-cycle instruction did not flush four clocks");
	a_read_before_write: assert property (commit && mie_needs_file(dec.op) |-> $past(file_rd_o, 2))
		else $error("file register not read before modify");
	a_dest_to_acc: assert property (commit && dec.op inside {OP_ROT_L, OP_ROT_R} && !dec.dest
		|=> !file_wr_o && acc_q == $past(res))
		else $error("destination zero did not reach accumulator");
	a_rot_left_carry: assert property (commit && dec.op == OP_ROT_L
		|=> c_q == $past(fdat_q[7]) && z_q == $past(z_q))
		else $error("rotate left carry wrong");
	a_rot_right_carry: assert property (commit && dec.op == OP_ROT_R
		|=> c_q == $past(fdat_q[0]) && ($past(dec.dest) || acc_q[7] == $past(c_q)))
		else $error("rotate right carry wrong");
	a_sub_result: assert property (commit && dec.op == OP_LIT_SUB
		|=> acc_q == 8'($past(dec.lit8) - $past(acc_q))
		&& c_q == ($past(acc_q) <= $past(dec.lit8)))
		else $error("literal minus accumulator wrong");
	a_sub_zero: assert property (commit && dec.op == OP_LIT_SUB |=> z_q == (acc_q == 8'h00))
		else $error("zero flag wrong after subtract");
	a_sleep_effects: assert property (commit && dec.op == OP_SLEEP
		|=> watchdog_clear_o && prescaler_clear_o && !powerdown_flag_q
		&& watchdog_expiry_flag_q && osc_stop_o)
		else $error("sleep effects missing");
	a_pd_only_sleep: assert property ($fell(powerdown_flag_q)
		|-> $past(commit && dec.op == OP_SLEEP))
		else $error("powerdown cleared without sleep");

	c_rotate_to_file: cover property (commit && dec.op == OP_ROT_L && dec.dest);
	c_skip_taken: cover property (commit && take_skip);
	c_sleep_wake: cover property (state_q == ST_SLEEP ##1 state_q == ST_IDLE);
	c_sub_borrow: cover property (commit && dec.op == OP_LIT_SUB && !c_n);

endmodule : mie_exec

/* include/mie_pkg.sv */
// Shared constants, types and decode function for the instruction execute block
package mie_pkg;

	// Word and field widths
	localparam int unsigned IW     = 14;
	localparam int unsigned DW     = 8;
	localparam int unsigned FAW    = 7;
	localparam int unsigned PCW    = 11;
	localparam int unsigned OSC_PER_ICYC = 4;

	// Register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC   = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_PC    = 8'h0c;
	localparam logic [7:0] OFS_CTRL  = 8'h10;

	// Status bit positions
	localparam int unsigned ST_C  = 0;
	localparam int unsigned ST_DC = 1;
	localparam int unsigned ST_Z  = 2;
	localparam int unsigned ST_PD = 3;
	localparam int unsigned ST_TO = 4;

	// Control bit positions
	localparam int unsigned CT_BUSY  = 0;
	localparam int unsigned CT_SLEEP = 1;
	localparam int unsigned CT_ILL   = 2;
	localparam int unsigned CT_WAKE  = 0;

	// Reset values
	localparam logic [7:0]  ACC_RST = 8'h00;
	localparam logic [10:0] PC_RST  = 11'h000;
	localparam logic [13:0] IR_RST  = 14'h0000;

	// Phases of one instruction cycle
	localparam logic [1:0] Q_DECODE = 2'h0;
	localparam logic [1:0] Q_READ   = 2'h1;
	localparam logic [1:0] Q_LATCH  = 2'h2;
	localparam logic [1:0] Q_COMMIT = 2'h3;

	// Fixed encodings
	localparam logic [13:0] SLEEP_WORD = 14'h0063;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EXEC  = 2'b01,
		ST_FLUSH = 2'b11,
		ST_SLEEP = 2'b10
	} mie_state_e;

	typedef enum logic [3:0] {
		OP_NOP, OP_ROT_L, OP_ROT_R, OP_CLR_F, OP_MOVE_F, OP_BIT_CLR, OP_BIT_SET,
		OP_SKIP_CLR, OP_SKIP_SET, OP_LOAD_LIT, OP_LIT_SUB, OP_JUMP, OP_SLEEP, OP_ILLEGAL
	} mie_op_e;

	typedef struct packed {
		mie_op_e     op;
		logic        dest;
		logic [6:0]  faddr;
		logic [2:0]  bsel;
		logic [7:0]  lit8;
		logic [10:0] lit11;
	} mie_dec_s;

	function automatic mie_dec_s mie_decode(input logic [13:0] w);
		mie_dec_s d;
		d.op    = OP_ILLEGAL;
		d.dest  = w[7];
		d.faddr = w[6:0];
		d.bsel  = w[9:7];
		d.lit8  = w[7:0];
		d.lit11 = w[10:0];
		case (w[13:12])
			2'b00:
			begin
				case (w[11:8])
					4'hd: d.op = OP_ROT_L;
					4'hc: d.op = OP_ROT_R;
					4'h8: d.op = OP_MOVE_F;
					4'h1: d.op = w[7] ? OP_CLR_F : OP_ILLEGAL;
					4'h0:
					begin
						if (w == SLEEP_WORD)
							d.op = OP_SLEEP;
						else if (!w[7] && w[4:0] == 5'h00)
							d.op = OP_NOP;
					end
					default: d.op = OP_ILLEGAL;
				endcase
			end
			2'b01:
			begin
				case (w[11:10])
					2'b00:   d.op = OP_BIT_CLR;
					2'b01:   d.op = OP_BIT_SET;
					2'b10:   d.op = OP_SKIP_CLR;
					default: d.op = OP_SKIP_SET;
				endcase
			end
			2'b10: d.op = w[11] ? OP_JUMP : OP_ILLEGAL;
			default:
			begin
				if (w[11:10] == 2'b00)
					d.op = OP_LOAD_LIT;
				else if (w[11:9] == 3'b110)
					d.op = OP_LIT_SUB;
			end
		endcase
		return d;
	endfunction : mie_decode

	function automatic logic mie_needs_file(input mie_op_e op);
		return op inside {OP_ROT_L, OP_ROT_R, OP_CLR_F, OP_MOVE_F,
			OP_BIT_CLR, OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET};
	endfunction : mie_needs_file

endpackage : mie_pkg

/* verification/mcu_instruction_execute_test.sv */
// Self-checking testbench for the instruction execute block
`timescale 1ns/1ps
`define CHK(what, exp, got) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("mismatch %s expected %0h seen %0h", what, exp, got); \
		end \
	end
module mcu_instruction_execute_test
	import mie_pkg::*;
;
	logic        clk;
	logic        rst_b;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        file_rd_o;
	logic        file_wr_o;
	logic [6:0]  file_addr_o;
	logic [7:0]  file_wdata_o;
	logic [7:0]  file_rdata_i;
	logic        wdt_expired_i;
	logic        watchdog_clear_o;
	logic        prescaler_clear_o;
	logic        osc_stop_o;
	logic [7:0]  fmem [128];
	logic [7:0]  acc_v [4] = '{8'h10, 8'h20, 8'h01, 8'hff};
	logic [7:0]  lit_v [4] = '{8'h10, 8'h10, 8'h10, 8'h00};
	logic [31:0] d;
	logic [7:0]  a;
	logic [7:0]  k;
	int          error_cnt;
	int          num_checks;
	int          cyc_n;
	int          rd_cnt;
	int          rd_at;
	int          wr_at;
	int          wd_cnt;
	int          mark;

	mie_exec #(.AW(8)) i_dut (
		.clk               (clk),
		.rst_b             (rst_b),
		.wb_cyc_i          (wb_cyc_i),
		.wb_stb_i          (wb_stb_i),
		.wb_we_i           (wb_we_i),
		.wb_adr_i          (wb_adr_i),
		.wb_sel_i          (wb_sel_i),
		.wb_dat_i          (wb_dat_i),
		.wb_dat_o          (wb_dat_o),
		.wb_ack_o          (wb_ack_o),
		.file_rd_o         (file_rd_o),
		.file_wr_o         (file_wr_o),
		.file_addr_o       (file_addr_o),
		.file_wdata_o      (file_wdata_o),
		.file_rdata_i      (file_rdata_i),
		.wdt_expired_i     (wdt_expired_i),
		.watchdog_clear_o  (watchdog_clear_o),
		.prescaler_clear_o (prescaler_clear_o),
		.osc_stop_o        (osc_stop_o)
	);

	always #10 clk = ~clk;

	// File register space and strobe bookkeeping
	always @(posedge clk)
	begin
		if (file_rd_o === 1'b1)
		begin
			file_rdata_i <= fmem[file_addr_o];
			rd_cnt++;
			rd_at = cyc_n;
		end
		else
			file_rdata_i <= ~file_rdata_i;
		if (file_wr_o === 1'b1)
		begin
			fmem[file_addr_o] = file_wdata_o;
			wr_at = cyc_n;
		end
		if (watchdog_clear_o === 1'b1 && prescaler_clear_o === 1'b1)
			wd_cnt++;
		cyc_n++;
	end

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic wb_xfer(input logic w, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rd);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : wb_xfer

	// Issue one word, look at busy six cycles on, then wait for idle
	task automatic run(input logic [13:0] w, input logic lng);
		logic [31:0] r;
		wb_xfer(1'b1, OFS_INSTR, {18'h0, w}, r);
		repeat (3) @(posedge clk);
		wb_xfer(1'b0, OFS_CTRL, 32'h0, r);
		`CHK("busy after six cycles", lng, r[0]);
		while (r[0] !== 1'b0)
			wb_xfer(1'b0, OFS_CTRL, 32'h0, r);
	endtask : run

	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		file_rdata_i = 8'h00;
		wdt_expired_i = 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		wb_xfer(1'b0, OFS_STAT, 32'h0, d);
		`CHK("status at reset", 5'h18, d[4:0]);
		wb_xfer(1'b0, 8'h1c, 32'h0, d);
		`CHK("unmapped read", 32'h0, d);
		// Rotate left into the file register at the top address
		fmem[7'h7f] = 8'he6;
		wb_xfer(1'b1, OFS_STAT, 32'h0, d);
		mark = rd_cnt;
		run(14'h0dff, 1'b0);
		`CHK("rotl file", 8'hcc, fmem[7'h7f]);
		`CHK("read count", mark + 1, rd_cnt);
		`CHK("read to write", 3, wr_at - rd_at);
		wb_xfer(1'b0, OFS_STAT, 32'h0, d);
		`CHK("rotl flags", 3'b001, d[2:0]);
		// Rotate left into the accumulator, zero left set
		fmem[7'h05] = 8'h81;
		wb_xfer(1'b1, OFS_STAT, 32'h5, d);
		run(14'h0d05, 1'b0);
		wb_xfer(1'b0, OFS_ACC, 32'h0, d);
		`CHK("rotl acc", 8'h03, d[7:0]);
		`CHK("file kept", 8'h81, fmem[7'h05]);
		wb_xfer(1'b0, OFS_STAT, 32'h0, d);
		`CHK("rotl z kept", 3'b101, d[2:0]);
		// Rotate right to a zero value, zero flag untouched
		fmem[7'h10] = 8'h01;
		wb_xfer(1'b1, OFS_STAT, 32'h0, d);
		run(14'h0c90, 1'b0);
		`CHK("rotr file", 8'h00, fmem[7'h10]);
		wb_xfer(1'b0, OFS_STAT, 32'h0, d);
		`CHK("rotr flags", 3'b001, d[2:0]);
		// Literal minus accumulator, borrow boundaries
		for (int i = 0; i < 4; i++)
		begin
			a = acc_v[i];
			k = lit_v[i];
			wb_xfer(1'b1, OFS_ACC, {24'h0, a}, d);
			run({6'h3c, k}, 1'b0);
			wb_xfer(1'b0, OFS_ACC, 32'h0, d);
			`CHK("difference", 8'(k - a), d[7:0]);
			wb_xfer(1'b0, OFS_STAT, 32'h0, d);
			`CHK("sub flags", {8'(k - a) == 8'h00, a[3:0] <= k[3:0], a <= k}, d[2:0]);
		end
		// Bit set on bit 7
		fmem[7'h33] = 8'h00;
		run(14'h17b3, 1'b0);
		`CHK("bit set", 8'h80, fmem[7'h33]);
		run(14'h305a, 1'b0);
		wb_xfer(1'b0, OFS_ACC, 32'h0, d);
		`CHK("load literal", 8'h5a, d[7:0]);
		// Jump, then taken and untaken skips
		run(14'h2da5, 1'b1);
		wb_xfer(1'b0, OFS_PC, 32'h0, d);
		`CHK("jump target", 11'h5a5, d[10:0]);
		fmem[7'h20] = 8'h00;
		run(14'h19a0, 1'b1);
		wb_xfer(1'b0, OFS_PC, 32'h0, d);
		`CHK("skip target", 11'h5a7, d[10:0]);
		run(14'h1da0, 1'b0);
		wb_xfer(1'b0, OFS_PC, 32'h0, d);
		`CHK("no skip", 11'h5a8, d[10:0]);
		// Clear still reads the register first
		fmem[7'h44] = 8'ha5;
		mark = rd_cnt;
		run(14'h01c4, 1'b0);
		`CHK("clear file", 8'h00, fmem[7'h44]);
		`CHK("clear read", mark + 1, rd_cnt);
		// Move to accumulator, bit clear empties the register
		run(14'h087f, 1'b0);
		wb_xfer(1'b0, OFS_ACC, 32'h0, d);
		`CHK("move to acc", 8'hcc, d[7:0]);
		run(14'h13b3, 1'b0);
		`CHK("bit clear", 8'h00, fmem[7'h33]);
		// Unsupported word flagged and flag cleared
		run(14'h2000, 1'b0);
		wb_xfer(1'b0, OFS_CTRL, 32'h0, d);
		`CHK("illegal set", 1'b1, d[2]);
		wb_xfer(1'b1, OFS_CTRL, 32'h4, d);
		wb_xfer(1'b0, OFS_CTRL, 32'h0, d);
		`CHK("illegal clear", 1'b0, d[2]);
		// Sleep with watchdog clear pulse, then wake by write
		mark = wd_cnt;
		wb_xfer(1'b1, OFS_INSTR, {18'h0, SLEEP_WORD}, d);
		repeat (6) @(posedge clk);
		`CHK("watchdog clears", mark + 1, wd_cnt);
		`CHK("osc stopped", 1'b1, osc_stop_o);
		wb_xfer(1'b0, OFS_STAT, 32'h0, d);
		`CHK("sleep flags", 2'b10, d[4:3]);
		wb_xfer(1'b1, OFS_CTRL, 32'h1, d);
		repeat (3) @(posedge clk);
		`CHK("osc running", 1'b0, osc_stop_o);
		// Sleep again, wake by watchdog expiry
		wb_xfer(1'b1, OFS_INSTR, {18'h0, SLEEP_WORD}, d);
		repeat (6) @(posedge clk);
		`CHK("osc stopped again", 1'b1, osc_stop_o);
		wdt_expired_i <= 1'b1;
		@(posedge clk);
		wdt_expired_i <= 1'b0;
		@(posedge clk);
		`CHK("woken by expiry", 1'b0, osc_stop_o);
		wb_xfer(1'b0, OFS_STAT, 32'h0, d);
		`CHK("after expiry", 2'b00, d[4:3]);
		close_out();
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		close_out();
	end
endmodule : mcu_instruction_execute_test
